// File: src/debounce_if.sv
// Interface carrying the qualifier result back to the top module
`timescale 1ns/10ps
interface debounce_if;
	logic state;
	logic fall;
	modport qual (output state, output fall);
	modport user (input state, input fall);
endinterface

// File: src/debounce_pkg.sv
// Constants shared by the pushbutton debounce toggle design
package debounce_pkg;
	localparam int unsigned CLK_FREQ_HZ = 100_000_000;
	localparam int unsigned DEBOUNCE_MS = 50;
	// Cycles of stable input needed before the debounced state moves
	localparam int unsigned QUAL_CYCLES = (CLK_FREQ_HZ / 1000) * DEBOUNCE_MS;
	localparam int unsigned SAMPLE_DIV = 1;
	localparam logic RELEASED_LEVEL = 1'b1;
	localparam logic LATCH_OFF = 1'b0;
endpackage

// File: src/debounce_qualifier.sv
// Stable-level qualifier: counter with restart on mismatch
`timescale 1ns/10ps
module debounce_qualifier #(
	parameter int unsigned QUAL_CYCLES = debounce_pkg::QUAL_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_hold,
	input wire logic i_sample,
	debounce_if.qual bus
);
	typedef struct packed {
		logic [31:0] cnt;
		logic state;
		logic fall;
	} qual_state_type;
	qual_state_type s_q;
	qual_state_type s_d;

	// Restart on mismatch, load raw level once stable long enough
	always_comb begin
		s_d = s_q;
		s_d.fall = 1'b0;
		if (i_hold) begin
			s_d.cnt = '0; // Input ignored while supply is low
		end else if (i_sample == s_q.state) begin
			s_d.cnt = '0;
		end else if (s_q.cnt >= QUAL_CYCLES - 1) begin
			s_d.cnt = '0;
			s_d.state = i_sample;
			s_d.fall = s_q.state & ~i_sample;
		end else begin
			s_d.cnt = s_q.cnt + 32'h1;
		end
	end

	// Released level after reset so nothing toggles at start
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '{cnt: '0, state: debounce_pkg::RELEASED_LEVEL, fall: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign bus.state = s_q.state;
	assign bus.fall = s_q.fall;

	chk_state_needs_count: assert property (
		@(posedge i_clk) disable iff (i_rst)
		$changed(s_q.state) |-> $past(s_q.cnt) >= QUAL_CYCLES - 1)
		else $error("debounced state moved before qualification ended");
	chk_mismatch_restart: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(i_sample == s_q.state) |=> s_q.cnt == 0)
		else $error("counter not restarted on matching level");
	chk_hold_freezes: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_hold |=> $stable(s_q.state))
		else $error("input accepted during undervoltage hold");
endmodule // debounce_qualifier

// File: src/pushbutton_debounce_toggle.sv
// Push-on/push-off controller with debounce and toggle latch
`timescale 1ns/10ps
// Summary of operation
// - Outputs always complementary, each accepted closure flips
// - Switch release never changes outputs
// - Level must hold 50 ms before accepted
// - Mismatch restarts the qualification counter
// - Stable period end loads raw level
// - Toggle only on debounced falling edge
// - Force off asynchronously clears the toggle
// - Undervoltage holds output low, ignores input
// - Idle input high, pressed switch pulls low
module pushbutton_debounce_toggle #(
	parameter int unsigned CLK_FREQ_HZ = debounce_pkg::CLK_FREQ_HZ,
	parameter int unsigned DEBOUNCE_MS = debounce_pkg::DEBOUNCE_MS,
	parameter int unsigned QUAL_CYCLES = (CLK_FREQ_HZ / 1000) * DEBOUNCE_MS
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_button_sense_n,
	input wire logic i_force_off,
	input wire logic i_undervoltage,
	output logic o_latched_level,
	output logic o_latched_level_n
);
	// Pin synchronisers, cleared only by power-on reset: if force off
	// also cleared them, a switch held through a long force off would
	// read as released and then pressed again, and toggle the latch
	typedef struct packed {
		logic [1:0] sense_sync;
		logic [1:0] uv_sync;
	} top_state_type;

	// Latch with its release synchroniser; force off clears both
	typedef struct packed {
		logic [1:0] clr_sync;
		logic toggle;
		logic toggle_n;
	} latch_state_type;

	top_state_type s_q;
	top_state_type s_d;
	latch_state_type l_q;
	latch_state_type l_d;
	logic clear_async;
	logic uv_hold;
	logic sense_sampled;
	logic clr_blocked;
	logic press_event;
	debounce_if qbus();

	// Next latch level: lockout wins over a press in the same cycle
	function automatic logic next_latch(
		input logic cur,
		input logic hold,
		input logic press
	);
		logic nxt;
		nxt = cur;
		if (hold) begin
			nxt = debounce_pkg::LATCH_OFF;
		end else if (press) begin
			nxt = ~cur;
		end
		return nxt;
	endfunction

	// Force off acts without the clock; merged with power-on reset
	assign clear_async = i_rst | i_force_off;

	// Synchronised pin levels under readable names
	assign uv_hold = s_q.uv_sync[1];
	assign sense_sampled = s_q.sense_sync[1]; // Low means pressed
	assign clr_blocked = l_q.clr_sync[1];

	// Presses right after force off release are dropped on purpose:
	// the clear pin is asynchronous and the latch must not race it.
	// Only a debounced fall counts, so a release never flips anything
	assign press_event = qbus.fall & ~clr_blocked;

	// Qualifier sees only the second synchroniser stage
	debounce_qualifier #(
		.QUAL_CYCLES(QUAL_CYCLES)
	) u_qual (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_hold(uv_hold),
		.i_sample(sense_sampled),
		.bus(qbus.qual)
	);

	// Two flip-flops on the sense and lockout pins before any logic
	always_comb begin
		s_d = s_q;
		s_d.sense_sync = {s_q.sense_sync[0], i_button_sense_n};
		s_d.uv_sync = {s_q.uv_sync[0], i_undervoltage};
	end

	// Sense stages reset to the released level, lockout stages to off
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '{sense_sync: {2{debounce_pkg::RELEASED_LEVEL}}, uv_sync: 2'h0};
		end else begin
			s_q <= s_d;
		end
	end

	// Latch flips only on an accepted debounced press; lockout forces it off
	always_comb begin
		l_d = l_q;
		l_d.clr_sync = {l_q.clr_sync[0], 1'b0};
		l_d.toggle = next_latch(l_q.toggle, uv_hold, press_event);
		l_d.toggle_n = ~l_d.toggle;
	end

	// Cleared asynchronously; clear-release stages start blocked
	always_ff @(posedge i_clk or posedge clear_async) begin
		if (clear_async) begin
			l_q <= '{clr_sync: 2'h3, toggle: debounce_pkg::LATCH_OFF,
				toggle_n: ~debounce_pkg::LATCH_OFF};
		end else begin
			l_q <= l_d;
		end
	end

	// Both outputs straight from the latch flip-flops
	assign o_latched_level = l_q.toggle;
	assign o_latched_level_n = l_q.toggle_n;

	// Checks below watch the latch in the clock domain. Those about
	// toggling are disabled while the clear is asserted, since the
	// latch then moves without the clock. The synchroniser checks skip
	// the two cycles after a reset, when the stages still hold their
	// reset levels rather than what the pins showed.

	// Press accepted by the latch in this cycle
	sequence seq_press_accepted;
		qbus.fall && !uv_hold && !clr_blocked;
	endsequence

	// No press can reach the latch in this cycle
	sequence seq_no_press;
		!qbus.fall && !uv_hold;
	endsequence

	// Output level differs from the cycle before
	sequence seq_latch_flipped;
		o_latched_level != $past(o_latched_level);
	endsequence

	// Output went from off to on at this edge
	sequence seq_output_rose;
		$rose(o_latched_level);
	endsequence

	// Complementary outputs outside power-on reset
	chk_outputs_complement: assert property (
		@(posedge i_clk) disable iff (i_rst)
		o_latched_level != o_latched_level_n)
		else $error("latched outputs not complementary");

	// An accepted press flips the latch one edge later
	chk_toggle_on_fall: assert property (
		@(posedge i_clk) disable iff (clear_async)
		seq_press_accepted |=> seq_latch_flipped)
		else $error("debounced press did not flip output");

	// Without a debounced press the level stays put
	chk_release_holds: assert property (
		@(posedge i_clk) disable iff (clear_async)
		seq_no_press |=> $stable(o_latched_level))
		else $error("output changed without a debounced press");

	// Force off holds the outputs off without waiting
	chk_force_off_low: assert property (
		@(posedge i_clk)
		i_force_off |-> !o_latched_level && o_latched_level_n)
		else $error("force off did not hold output low");

	// Lockout drives the output off
	chk_uv_low: assert property (
		@(posedge i_clk) disable iff (i_rst)
		uv_hold |=> !o_latched_level)
		else $error("output high during undervoltage");

	// Just after force off release the latch ignores presses
	chk_clear_blocks: assert property (
		@(posedge i_clk) disable iff (clear_async)
		(clr_blocked && !uv_hold) |=> $stable(o_latched_level))
		else $error("latch moved while clear release was pending");

	// Turning on needs a debounced fall the edge before
	chk_rise_needs_press: assert property (
		@(posedge i_clk) disable iff (clear_async)
		seq_output_rose |-> $past(qbus.fall))
		else $error("output turned on without a debounced press");

	// Lockout keeps the qualifier from reporting presses
	chk_uv_blocks_fall: assert property (
		@(posedge i_clk) disable iff (i_rst)
		uv_hold |=> !qbus.fall)
		else $error("debounced press reported during lockout");

	// Sense line passes exactly two stages
	chk_sense_sync_path: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(!$past(i_rst) && !$past(i_rst, 2)) |->
		sense_sampled == $past(i_button_sense_n, 2))
		else $error("sense synchroniser latency wrong");

	// Lockout pin passes exactly two stages
	chk_uv_sync_path: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(!$past(i_rst) && !$past(i_rst, 2)) |->
		uv_hold == $past(i_undervoltage, 2))
		else $error("lockout synchroniser latency wrong");
endmodule // pushbutton_debounce_toggle

// File: test/pushbutton_debounce_toggle_tb.sv
// Self-checking bench for the debounce toggle controller
`timescale 1ns/10ps
module pushbutton_debounce_toggle_tb;
	logic i_clk = 1'b0;
	logic i_rst = 1'b0;
	logic press = 1'b0;
	logic force_off = 1'b0;
	logic uv = 1'b0;
	logic sense_n;
	logic lvl;
	logic lvl_n;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;
	always #5 i_clk = ~i_clk;
	switch_model switch_model_inst (.i_press(press), .o_sense_n(sense_n));
	// Short count keeps each qualification to a few cycles
	pushbutton_debounce_toggle #(.QUAL_CYCLES(8)) pushbutton_debounce_toggle_inst (
		.i_clk(i_clk), .i_rst(i_rst), .i_button_sense_n(sense_n),
		.i_force_off(force_off), .i_undervoltage(uv),
		.o_latched_level(lvl), .o_latched_level_n(lvl_n));
	task automatic results();
		$display("checks %0d bad %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Both outputs against one expected level
	task automatic check_out(input logic exp);
		samples_checked++;
		if (lvl !== exp || lvl_n !== ~exp) begin
			miscompares++;
			$display("BAD %0t out %b/%b want %b", $time, lvl, lvl_n, exp);
		end
	endtask
	// Switch held for n falling edges
	task automatic hold(input logic p, input int n);
		press = p;
		repeat (n) @(negedge i_clk);
	endtask
	// Clean press: not early, then on; release leaves it
	task automatic press_on();
		hold(1'b1, 7);
		check_out(1'b0);
		hold(1'b1, 6);
		check_out(1'b1);
		hold(1'b0, 14);
		check_out(1'b1);
	endtask
	// Bounce restarts the count, then a steady press turns off
	task automatic bounce();
		hold(1'b1, 6);
		hold(1'b0, 2);
		hold(1'b1, 6);
		check_out(1'b1);
		hold(1'b1, 6);
		check_out(1'b0);
		hold(1'b0, 14);
	endtask
	// Clear acts without waiting for a clock edge
	task automatic clear_out();
		hold(1'b1, 14);
		hold(1'b0, 14);
		force_off = 1'b1;
		#1 check_out(1'b0);
		@(negedge i_clk);
		force_off = 1'b0;
		hold(1'b0, 4);
		check_out(1'b0);
	endtask
	// Presses during lockout are ignored
	task automatic lockout();
		uv = 1'b1;
		hold(1'b0, 4);
		hold(1'b1, 14);
		check_out(1'b0);
		hold(1'b0, 14);
		uv = 1'b0;
		hold(1'b0, 4);
		check_out(1'b0);
		hold(1'b1, 14);
		check_out(1'b1);
	endtask
	// Hang guard, far beyond the planned run
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			results();
		end
	end
	initial begin
		// Raised at time zero so the asynchronous reset sees an edge
		i_rst = 1'b1;
		repeat (3) @(negedge i_clk);
		i_rst = 1'b0;
		check_out(1'b0);
		hold(1'b0, 14);
		check_out(1'b0);
		press_on();
		bounce();
		clear_out();
		lockout();
		results();
	end
endmodule // pushbutton_debounce_toggle_tb

// File: test/switch_model.sv
// Momentary switch to ground on a pulled-up sense line
`timescale 1ns/10ps
module switch_model (
	input wire logic i_press,
	output logic o_sense_n
);
	// Open contact leaves the pull-up in charge
	assign o_sense_n = i_press ? 1'b0 : 1'b1;
endmodule // switch_model
